// ### rtl/ladder_pkg.sv
// Package for the ladder boolean executor.
// Assumes one 25 MHz clock domain and synchronous active-high reset.
package ladder_pkg;
  localparam int INSTR_W      = 16;
  localparam int OP_W         = 4;
  localparam int BIT_ADDR_W   = 12;
  localparam int PROG_ADDR_W  = 10;
  localparam int STACK_DEPTH  = 8;
  localparam int OPC_MSB      = 15;
  localparam int OPC_LSB      = 12;
  localparam int BADDR_MSB    = 11;
  localparam int BADDR_LSB    = 0;
  localparam logic [PROG_ADDR_W-1:0] PROG_START = 10'h000;
  localparam logic [BIT_ADDR_W-1:0]  BADDR_ZERO = 12'h000;
  localparam logic [3:0] STACK_ZERO = 4'h0;
  localparam logic [3:0] STACK_ONE  = 4'h1;

  typedef enum logic [OP_W-1:0] {
    OP_NOP                  = 4'h0,
    OP_BLOCK_START          = 4'h1,
    OP_INV_BLOCK_START      = 4'h2,
    OP_SERIES               = 4'h3,
    OP_SERIES_INV           = 4'h4,
    OP_PARALLEL             = 4'h5,
    OP_PARALLEL_INV         = 4'h6,
    OP_CONJ_COMBINE         = 4'h7,
    OP_DISJ_COMBINE         = 4'h8,
    OP_COIL                 = 4'h9,
    OP_COIL_INV             = 4'hA,
    OP_TERMINATOR           = 4'hF
  } opcode_t;
endpackage

// ### rtl/cond_stack.sv
// Last-in first-out store of unused execution conditions.
// Assumes push and pop never arrive together; the caller checks full and empty.
`timescale 1ns/10ps
`default_nettype none
module cond_stack #(
  parameter int DEPTH = ladder_pkg::STACK_DEPTH
) (
  input  wire logic clock_in,
  input  wire logic srst_in,
  input  wire logic clear_in,
  input  wire logic push_in,
  input  wire logic push_bit_in,
  input  wire logic pop_in,
  output logic      top_out,
  output logic      empty_out,
  output logic      full_out
);
  import ladder_pkg::*;

  logic [DEPTH-1:0] store;
  logic [3:0]       count;

  assign top_out   = (count == STACK_ZERO) ? 1'b0 : store[count[2:0] - 3'h1];
  assign empty_out = (count == STACK_ZERO);
  assign full_out  = (count == 4'(DEPTH));

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in) begin
    if (srst_in || clear_in) begin
      count <= STACK_ZERO;
    end else if (push_in) begin
      store[count[2:0]] <= push_bit_in;
      count <= count + STACK_ONE;
    end else if (pop_in) begin
      count <= count - STACK_ONE;
    end
  end
endmodule
`default_nettype wire

// ### rtl/ladder_boolean_executor.sv
// Bit-logic executor stepping through a stored ladder instruction list.
// Assumes program and data memories answer reads in the next cycle.
//
// Overview of operation
// - Parallel contact ORs condition with operand bit or its inverse.
// - Contacts apply in program order, each feeding the next.
// - Series inverted contact ANDs condition with complemented operand bit.
// - Inverted block start begins condition as complement of operand.
// - Coil drive writes operand bit equal to execution condition.
// - Inverted coil drive writes operand bit as inverse of condition.
// - Scan runs to first terminator then restarts at address zero.
// - Terminator carries no operand bits; its condition is ignored.
// - Without any terminator the program never executes.
// - Block start mid-line saves current condition and starts fresh.
// - Only mid-line block starts create saved unused conditions.
// - Conjunctive combine ANDs condition with latest saved one, consuming it.
// - Disjunctive combine ORs condition with latest saved one, consuming it.
// - Combine instructions carry no operand bits.
// - Saved-condition buffer holds at most eight blocks.
// - Every contact and coil instruction occupies one line.
// - Series contact ANDs condition with operand bit.
// - Program addresses start at zero, one instruction each.
`timescale 1ns/10ps
`default_nettype none
module ladder_boolean_executor #(
  parameter int PROG_W = ladder_pkg::PROG_ADDR_W,
  parameter int BIT_W  = ladder_pkg::BIT_ADDR_W
) (
  input  wire logic                             clock_in,
  input  wire logic                             srst_in,
  input  wire logic                             run_in,
  output logic [PROG_W-1:0]                     prog_addr_out,
  input  wire logic [ladder_pkg::INSTR_W-1:0]   prog_data_in,
  input  wire logic                             prog_last_in,
  output logic [BIT_W-1:0]                      bit_addr_out,
  input  wire logic                             bit_data_in,
  output logic                                  bit_write_out,
  output logic                                  bit_wdata_out,
  output logic                                  scan_done_out,
  output logic                                  no_end_error_out,
  output logic                                  prog_error_out,
  output logic                                  exec_cond_out
);
  import ladder_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK_FETCH,
    ST_CHECK_DECODE,
    ST_FETCH,
    ST_OPERAND,
    ST_EXEC,
    ST_HALT
  } state_t;

  state_t             state;
  state_t             next_state;
  logic [PROG_W-1:0]  pc;
  logic [INSTR_W-1:0] instr;
  logic               cond;
  logic               next_cond;
  logic               line_open;
  logic               found_end;
  logic               stack_top;
  logic               stack_empty;
  logic               stack_full;

  //////////////////////////////////////////////////////////////////////////
  // Opcode class decode
  function automatic logic is_terminator(input opcode_t op);
    return (op == OP_TERMINATOR);
  endfunction

  function automatic logic is_load_op(input opcode_t op);
    return (op == OP_BLOCK_START) || (op == OP_INV_BLOCK_START);
  endfunction

  function automatic logic is_combine_op(input opcode_t op);
    return (op == OP_CONJ_COMBINE) || (op == OP_DISJ_COMBINE);
  endfunction

  function automatic logic is_coil_op(input opcode_t op);
    return (op == OP_COIL) || (op == OP_COIL_INV);
  endfunction

  // Next word address, zero after a terminator
  function automatic logic [PROG_W-1:0] step_addr(input logic [PROG_W-1:0] addr,
                                                  input logic              wrap);
    return wrap ? PROG_W'(PROG_START) : addr + 1'b1;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Instruction field decode
  wire opcode_t           opc          = opcode_t'(instr[OPC_MSB:OPC_LSB]);
  wire opcode_t           fetch_opc    = opcode_t'(prog_data_in[OPC_MSB:OPC_LSB]);
  wire logic [BIT_W-1:0]  fetch_bit    = BIT_W'(prog_data_in[BADDR_MSB:BADDR_LSB]);
  wire logic              is_load      = is_load_op(opc);
  wire logic              is_comb      = is_combine_op(opc);
  wire logic              is_coil      = is_coil_op(opc);
  wire logic              is_end       = is_terminator(opc);
  wire logic              fetch_is_end = is_terminator(fetch_opc);
  wire logic              in_exec      = (state == ST_EXEC);
  wire logic              in_decode    = (state == ST_CHECK_DECODE);
  wire logic              in_operand   = (state == ST_OPERAND);
  wire logic              in_fetch     = (state == ST_FETCH);
  wire logic              in_idle      = (state == ST_IDLE);

  //////////////////////////////////////////////////////////////////////////
  // Address stepping
  wire logic [PROG_W-1:0] scan_next_pc = step_addr(pc, fetch_is_end);
  wire logic [PROG_W-1:0] run_next_pc  = step_addr(pc, is_end);
  // Prescan moves to the next word
  wire logic              scan_step    = in_decode && (next_state == ST_CHECK_FETCH);

  //////////////////////////////////////////////////////////////////////////
  // mid-line load saves condition
  wire logic              do_push      = in_exec && is_load && line_open && !stack_full;
  wire logic              do_pop       = in_exec && is_comb && !stack_empty;
  wire logic              end_fire     = in_exec && is_end;
  wire logic              err_event    = in_exec && ((is_comb && stack_empty) ||
                                                     (is_load && line_open && stack_full));
  wire logic              cond_load    = in_exec && !err_event;
  wire logic              coil_fire    = in_exec && is_coil;
  wire logic              coil_value   = (opc == OP_COIL_INV) ? ~cond : cond;
  wire logic              missing_end  = in_decode && !fetch_is_end && prog_last_in;

  //////////////////////////////////////////////////////////////////////////
  // eight entry buffer
  cond_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .clock_in    (clock_in),
    .srst_in     (srst_in),
    .clear_in    (end_fire),
    .push_in     (do_push),
    .push_bit_in (cond),
    .pop_in      (do_pop),
    .top_out     (stack_top),
    .empty_out   (stack_empty),
    .full_out    (stack_full)
  );

  //////////////////////////////////////////////////////////////////////////
  // Condition evaluation
  always_comb begin
    next_cond = cond;
    unique case (opc)
      OP_BLOCK_START:     next_cond = bit_data_in;
      OP_INV_BLOCK_START: next_cond = ~bit_data_in;
      OP_SERIES:          next_cond = cond & bit_data_in;
      OP_SERIES_INV:      next_cond = cond & ~bit_data_in;
      OP_PARALLEL:        next_cond = cond | bit_data_in;
      OP_PARALLEL_INV:    next_cond = cond | ~bit_data_in;
      OP_CONJ_COMBINE:    next_cond = stack_empty ? cond : (cond & stack_top);
      OP_DISJ_COMBINE:    next_cond = stack_empty ? cond : (cond | stack_top);
      default:            next_cond = cond;
    endcase
  end

  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:         next_state = run_in ? ST_CHECK_FETCH : ST_IDLE;
      // Second pass primes word zero
      ST_CHECK_FETCH:  next_state = found_end ? ST_FETCH : ST_CHECK_DECODE;
      ST_CHECK_DECODE: next_state = (fetch_is_end || !prog_last_in) ? ST_CHECK_FETCH : ST_HALT;
      ST_FETCH:        next_state = ST_OPERAND;
      ST_OPERAND:      next_state = ST_EXEC;
      ST_EXEC:         next_state = err_event ? ST_HALT : ST_FETCH;
      ST_HALT:         next_state = ST_HALT;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in || in_idle) begin
      pc <= PROG_W'(PROG_START);
    end else if (in_decode) begin
      pc <= scan_next_pc;
    end else if (in_operand) begin
      pc <= run_next_pc;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in || in_idle) begin
      found_end <= 1'b0;
    end else if (in_decode && fetch_is_end) begin
      found_end <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      instr <= '0;
    end else if (in_fetch) begin
      instr <= prog_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cond <= 1'b0;
    end else if (cond_load) begin
      cond <= next_cond;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      line_open <= 1'b0;
    end else if (cond_load && (is_load || is_comb)) begin
      line_open <= 1'b1;
    end else if (cond_load && is_end) begin
      line_open <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Program address leads the fetch by one cycle
  always_ff @(posedge clock_in) begin
    if (srst_in || in_idle) begin
      prog_addr_out <= PROG_W'(PROG_START);
    end else if (scan_step) begin
      prog_addr_out <= scan_next_pc;
    end else if (in_operand) begin
      prog_addr_out <= run_next_pc;
    end
  end

  // Operand bit address
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      bit_addr_out <= BIT_W'(BADDR_ZERO);
    end else if (in_fetch) begin
      bit_addr_out <= fetch_bit;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      bit_write_out <= 1'b0;
    end else begin
      bit_write_out <= coil_fire;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      bit_wdata_out <= 1'b0;
    end else begin
      bit_wdata_out <= coil_value;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      scan_done_out <= 1'b0;
    end else begin
      scan_done_out <= end_fire;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      no_end_error_out <= 1'b0;
    end else if (missing_end) begin
      no_end_error_out <= 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      prog_error_out <= 1'b0;
    end else if (err_event) begin
      prog_error_out <= 1'b1;
    end
  end

  // Condition monitor
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      exec_cond_out <= 1'b0;
    end else begin
      exec_cond_out <= cond;
    end
  end
endmodule
`default_nettype wire

// ### sim/ladder_executor_properties.sv
// Port checker for the ladder boolean executor.
// Assumes one clock domain and synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module ladder_executor_checker #(
  parameter int PROG_W = 10
) (
  input wire logic              clock_in,
  input wire logic              srst_in,
  input wire logic [PROG_W-1:0] prog_addr_out,
  input wire logic              bit_write_out,
  input wire logic              scan_done_out,
  input wire logic              no_end_error_out,
  input wire logic              prog_error_out,
  input wire logic              exec_cond_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);
  sequence s_done;
    $rose(scan_done_out);
  endsequence
  sequence s_restart;
    prog_addr_out == '0;
  endsequence
  a_reset_clears_all: assert property ($fell(srst_in) |-> prog_addr_out == '0 && !exec_cond_out
    && !bit_write_out && !scan_done_out && !prog_error_out && !no_end_error_out)
    else $error("outputs not clear after reset");
  a_done_restarts_zero: assert property (s_done |-> ##[0:4] s_restart)
    else $error("scan did not restart at address zero");
  a_done_single_pulse: assert property (s_done |=> $fell(scan_done_out))
    else $error("scan done longer than one cycle");
  a_write_single_pulse: assert property (bit_write_out |=> !bit_write_out)
    else $error("write pulse longer than one cycle");
  a_fetch_in_order: assert property ($changed(prog_addr_out) |->
    prog_addr_out == $past(prog_addr_out) + 1'b1 || prog_addr_out == '0)
    else $error("program address skipped");
  a_noend_sticky_idle: assert property (no_end_error_out |=> no_end_error_out && !scan_done_out)
    else $error("missing terminator flag dropped or scan ran");
  a_noend_no_write: assert property (no_end_error_out |-> !bit_write_out [*4])
    else $error("write without terminator");
  a_error_halts_unit: assert property (prog_error_out |=>
    prog_error_out && !bit_write_out && !scan_done_out)
    else $error("executor ran on after program error");
endmodule
bind ladder_boolean_executor ladder_executor_checker #(.PROG_W(PROG_W)) u_chk (
  .clock_in(clock_in), .srst_in(srst_in), .prog_addr_out(prog_addr_out),
  .bit_write_out(bit_write_out), .scan_done_out(scan_done_out),
  .no_end_error_out(no_end_error_out), .prog_error_out(prog_error_out),
  .exec_cond_out(exec_cond_out));
`default_nettype wire

// ### sim/ladder_memory_model.sv
// Program memory and bit data memory facing the executor.
// Assumes the bench loads both arrays while the executor is in reset.
`timescale 1ns/10ps
`default_nettype none
module ladder_memory_model (
  input  wire logic        clock_in,
  input  wire logic [9:0]  prog_addr_in,
  output var logic  [15:0] prog_data_out,
  output var logic         prog_last_out,
  input  wire logic [11:0] bit_addr_in,
  output var logic         bit_data_out,
  input  wire logic        bit_write_in,
  input  wire logic        bit_wdata_in
);
  logic [15:0] prog_mem [0:1023];
  logic        bit_mem  [0:4095];
  logic [9:0]  last_addr;
  always @(posedge clock_in) begin
    prog_data_out <= prog_mem[prog_addr_in];
    prog_last_out <= (prog_addr_in == last_addr);
    bit_data_out  <= bit_mem[bit_addr_in];
    if (bit_write_in) begin
      bit_mem[bit_addr_in] <= bit_wdata_in;
    end
  end
endmodule
`default_nettype wire

// ### sim/ladder_boolean_executor_tb.sv
// Self-checking bench for the ladder boolean executor.
// Assumes the memory model answers one cycle after each address.
`timescale 1ns/10ps
`default_nettype none
module ladder_boolean_executor_tb;
  import ladder_pkg::*;
  logic clock_in = 1'b0, srst_in = 1'b1, run_in = 1'b0;
  logic [9:0] pa;
  logic [15:0] pd;
  logic [11:0] ba;
  logic pl, bd, bw, bwd, done, noend, perr, cond;
  logic [15:0] lfsr = 16'hE6EF;
  logic [15:0] prog [0:1023];
  logic exp_bits [0:4095];
  logic [3:0] cops [4] = '{OP_SERIES, OP_SERIES_INV, OP_PARALLEL, OP_PARALLEL_INV};
  int plen, errors = 0, total_checks = 0;
  always #20 clock_in = ~clock_in;
  ladder_boolean_executor i_ladder_boolean_executor (.clock_in(clock_in), .srst_in(srst_in),
    .run_in(run_in), .prog_addr_out(pa), .prog_data_in(pd), .prog_last_in(pl),
    .bit_addr_out(ba), .bit_data_in(bd), .bit_write_out(bw), .bit_wdata_out(bwd),
    .scan_done_out(done), .no_end_error_out(noend), .prog_error_out(perr), .exec_cond_out(cond));
  ladder_memory_model u_mem (.clock_in(clock_in), .prog_addr_in(pa), .prog_data_out(pd),
    .prog_last_out(pl), .bit_addr_in(ba), .bit_data_out(bd), .bit_write_in(bw),
    .bit_wdata_in(bwd));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [11:0] addr();
    logic [15:0] r;
    r = rnd();
    return {4'h0, r[7:0]};
  endfunction
  function automatic void emit(input logic [3:0] op, input logic [11:0] a);
    prog[plen] = {op, a};
    plen++;
  endfunction
  function automatic void eval();
    logic c, b, open;
    logic q[$];
    logic [3:0] op;
    open = 1'b0;
    c = 1'b0;
    for (int i = 0; i < plen; i++) begin
      op = prog[i][15:12];
      b = exp_bits[prog[i][11:0]];
      if (op == OP_TERMINATOR) break;
      case (op)
        OP_BLOCK_START, OP_INV_BLOCK_START: begin
          if (open) q.push_back(c);
          c = (op == OP_INV_BLOCK_START) ? ~b : b;
          open = 1'b1;
        end
        OP_SERIES: c = c & b;
        OP_SERIES_INV: c = c & ~b;
        OP_PARALLEL: c = c | b;
        OP_PARALLEL_INV: c = c | ~b;
        OP_CONJ_COMBINE: c = c & q.pop_back();
        OP_DISJ_COMBINE: c = c | q.pop_back();
        OP_COIL: exp_bits[prog[i][11:0]] = c;
        OP_COIL_INV: exp_bits[prog[i][11:0]] = ~c;
        default: ;
      endcase
    end
  endfunction
  task automatic final_report();
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic exec_case(input logic [2:0] want, input logic model);
    logic [15:0] r;
    int n;
    @(posedge clock_in);
    srst_in <= 1'b1;
    run_in <= 1'b0;
    for (int i = 0; i < plen; i++) u_mem.prog_mem[i] = prog[i];
    u_mem.last_addr = 10'(plen - 1);
    for (int i = 0; i < 4096; i++) begin
      r = rnd();
      u_mem.bit_mem[i] = r[0];
      exp_bits[i] = r[0];
    end
    repeat (5) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    run_in <= 1'b1;
    for (n = 0; n < 4000; n++) begin
      @(posedge clock_in);
      #1;
      if (done === 1'b1 || noend === 1'b1 || perr === 1'b1) break;
    end
    if (n == 4000) begin
      errors++;
      final_report();
    end
    if (model) eval();
    check(16'({perr, noend, done}), 16'(want));
    for (int i = 0; i < 4096; i++) check(16'(u_mem.bit_mem[i]), 16'(exp_bits[i]));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] r;
    int depth;
    for (int t = 0; t < 20; t++) begin
      plen = 0;
      depth = 0;
      emit(OP_BLOCK_START, addr());
      for (int k = 0; k < 14; k++) begin
        r = rnd();
        case (int'(r % 16'h0009))
          0: if (depth < 7) begin
            emit(r[4] ? OP_INV_BLOCK_START : OP_BLOCK_START, addr());
            depth++;
          end
          1, 2, 3, 4: emit(cops[r[9:8]], addr());
          5: if (depth > 0) begin
            emit(r[4] ? OP_DISJ_COMBINE : OP_CONJ_COMBINE, 12'h000);
            depth--;
          end
          6, 7: emit(r[4] ? OP_COIL_INV : OP_COIL, 12'h800 + 12'(k));
          default: emit(OP_NOP, 12'h000);
        endcase
      end
      for (; depth > 0; depth--) emit(OP_CONJ_COMBINE, 12'h000);
      emit(OP_COIL, 12'h8F0);
      emit(OP_TERMINATOR, 12'h000);
      emit(OP_COIL, 12'hFFF);
      exec_case(3'h1, 1'b1);
    end
    plen = 0;
    for (int i = 0; i < 8; i++) emit(i[0] ? OP_INV_BLOCK_START : OP_BLOCK_START, addr());
    for (int i = 0; i < 7; i++) emit(i[0] ? OP_DISJ_COMBINE : OP_CONJ_COMBINE, 12'h000);
    emit(OP_COIL, 12'h800);
    emit(OP_TERMINATOR, 12'h000);
    exec_case(3'h1, 1'b1);
    plen = 0;
    emit(OP_BLOCK_START, 12'h001);
    emit(OP_COIL, 12'h801);
    exec_case(3'h2, 1'b0);
    plen = 0;
    emit(OP_BLOCK_START, 12'h002);
    emit(OP_CONJ_COMBINE, 12'h000);
    emit(OP_COIL, 12'h802);
    emit(OP_TERMINATOR, 12'h000);
    exec_case(3'h4, 1'b0);
    plen = 0;
    for (int i = 0; i < 10; i++) emit(OP_BLOCK_START, addr());
    emit(OP_COIL, 12'h803);
    emit(OP_TERMINATOR, 12'h000);
    exec_case(3'h4, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
